// ===== shared/drive_status_pkg.sv
package drive_status_pkg;

   // ***************************************
   // Units and widths
   // ***************************************
   // Frequencies in 0.01 Hz, torque in 0.1 %
   localparam int FW = 16;
   typedef logic [FW-1:0] freq_t;
   localparam int NUM_TERM = 7;

   // ***************************************
   // Timing
   // ***************************************
   localparam int CLK_HZ = 25_000_000;
   localparam int REGEN_HOLD_MS = 100;
   localparam int STALL_MS = 3000;
   localparam int REGEN_HOLD_CYC = REGEN_HOLD_MS * (CLK_HZ / 1000);
   localparam int STALL_CYC = STALL_MS * (CLK_HZ / 1000);

   // ***************************************
   // Register offsets
   // ***************************************
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_BAND = 8'h01;
   localparam logic [7:0] A_TH1 = 8'h02;
   localparam logic [7:0] A_THREV = 8'h03;
   localparam logic [7:0] A_TH2 = 8'h04;
   localparam logic [7:0] A_TH3 = 8'h05;
   localparam logic [7:0] A_LOW = 8'h06;
   localparam logic [7:0] A_STALL = 8'h07;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_SEL0 = 8'h10;

   // ***************************************
   // Reset values and limits
   // ***************************************
   localparam logic [6:0] BAND_RST = 7'h0a;
   localparam logic [6:0] BAND_MAX = 7'h64;
   localparam freq_t FREQ_MAX = 16'h9c40;
   localparam freq_t TH1_RST = 16'h0258;
   localparam freq_t REV_SAME = 16'h270f;
   localparam freq_t TH2_RST = 16'h0bb8;
   localparam freq_t TH3_RST = 16'h1770;
   localparam freq_t LOW_RST = 16'h0096;
   localparam logic [15:0] STALL_RST = 16'h05dc;

   // ***************************************
   // Control methods
   // ***************************************
   typedef enum logic [3:0] {
      CM_VF = 4'b0001,
      CM_FLUX = 4'b0010,
      CM_SLV = 4'b0100,
      CM_VEC = 4'b1000
   } ctrl_method_t;

   // ***************************************
   // Terminal selection codes
   // ***************************************
   localparam logic [7:0] NEG_OFS = 8'h64;
   localparam logic [7:0] SEL_SU = 8'h01;
   localparam logic [7:0] SEL_FU = 8'h04;
   localparam logic [7:0] SEL_FU2 = 8'h05;
   localparam logic [7:0] SEL_FU3 = 8'h06;
   localparam logic [7:0] SEL_REGEN = 8'h20;
   localparam logic [7:0] SEL_LS = 8'h22;
   localparam logic [7:0] SEL_FB = 8'h29;
   localparam logic [7:0] SEL_FB2 = 8'h2a;
   localparam logic [7:0] SEL_FB3 = 8'h2b;
   localparam logic [7:0] SEL_TRIP = 8'h5b;
   localparam logic [7:0] SEL_HELD = 8'h5e;
   localparam logic [7:0] SEL_FAULT = 8'h63;
   localparam logic [7:0] SEL_NONE = 8'hff;
   localparam int T_SU = 0;
   localparam int T_FU = 1;
   localparam int T_RELAY = 5;

   // Alarm causes that trip the input contactor
   localparam logic [4:0] CAUSE_FIRST = 5'h01;
   localparam logic [4:0] CAUSE_LAST = 5'h0b;

   // ***************************************
   // Carriers
   // ***************************************
   typedef struct packed {
      logic stopped;
      logic pre_excite;
      logic dc_brake;
      logic start_tuning;
      logic regen_status;
      logic alarm_stop;
      logic alarm_reset;
      logic reverse;
      logic speed_ctrl;
      logic torque_limiting;
      logic [4:0] alarm_cause;
   } drive_in_t;

   typedef struct packed {
      freq_t out_freq;
      freq_t slip_pre_freq;
      freq_t est_speed;
      freq_t fb_speed;
      freq_t set_freq;
      logic [15:0] torque;
   } freq_in_t;

   typedef struct packed {
      logic stall_alarm;
      logic input_contactor_trip;
      logic held_fault_out;
      logic fault_out;
      logic regen_flag;
      logic low_speed_flag;
      logic speed_detect_3;
      logic out_freq_detect_3;
      logic speed_detect_2;
      logic out_freq_detect_2;
      logic speed_detect_1;
      logic out_freq_detect_1;
      logic freq_reached;
   } flags_t;

endpackage : drive_status_pkg

// ===== rtl/drive_status_signal_generator.sv
`timescale 1ns/1ps
module drive_status_signal_generator
   import drive_status_pkg::*;
#(
   parameter int REGEN_HOLD_CYCLES = drive_status_pkg::REGEN_HOLD_CYC,
   parameter int STALL_CYCLES = drive_status_pkg::STALL_CYC,
   parameter int TERMS = drive_status_pkg::NUM_TERM
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [15:0] rdata,
   input drive_status_pkg::drive_in_t drv,
   input drive_status_pkg::freq_in_t frq,
   output drive_status_pkg::flags_t flags,
   output logic [TERMS-1:0] term_out
);
   import drive_status_pkg::*;

   localparam int HW = $clog2(REGEN_HOLD_CYCLES + 1);
   localparam int SW = $clog2(STALL_CYCLES + 1);
   localparam logic [HW-1:0] HOLD_LOAD = HW'(REGEN_HOLD_CYCLES - 1);
   localparam logic [SW-1:0] STALL_END = SW'(STALL_CYCLES);

   // ***************************************
   // State
   // ***************************************
   typedef struct packed {
      ctrl_method_t method;
      logic [6:0] band;
      freq_t th1;
      freq_t threv;
      freq_t th2;
      freq_t th3;
      freq_t low;
      logic [15:0] stall_lvl;
      logic [TERMS-1:0][7:0] sel;
      logic [HW-1:0] hold_cnt;
      logic [SW-1:0] stall_cnt;
      flags_t flg;
      logic [TERMS-1:0] term;
      logic [15:0] rdata;
   } st_t;

   st_t s_r;
   st_t s_nxt;
   freq_t cmp;
   freq_t spd;
   freq_t th_dir;
   logic blank;
   logic stall_cond;
   logic [7:0] sel_idx;

   // ***************************************
   // Helpers
   // ***************************************
   // Cross-multiplied so no divider is needed
   function automatic logic in_band(freq_t c, freq_t s, logic [6:0] b);
      logic [15:0] d;
      logic [23:0] lhs;
      logic [23:0] rhs;
      d = (c > s) ? c - s : s - c;
      lhs = 24'(d) * 24'h64;
      rhs = 24'(s) * 24'(b);
      return lhs <= rhs;
   endfunction : in_band

   // Unknown codes leave the terminal low in either polarity
   function automatic logic route(logic [7:0] code, flags_t f);
      logic neg;
      logic [7:0] base;
      logic v;
      logic hit;
      neg = code >= NEG_OFS;
      base = neg ? code - NEG_OFS : code;
      hit = 1'b1;
      v = 1'b0;
      case (base)
         SEL_SU: v = f.freq_reached;
         SEL_FU: v = f.out_freq_detect_1;
         SEL_FB: v = f.speed_detect_1;
         SEL_FU2: v = f.out_freq_detect_2;
         SEL_FB2: v = f.speed_detect_2;
         SEL_FU3: v = f.out_freq_detect_3;
         SEL_FB3: v = f.speed_detect_3;
         SEL_LS: v = f.low_speed_flag;
         SEL_REGEN: v = f.regen_flag;
         SEL_TRIP: v = f.input_contactor_trip;
         SEL_HELD: v = f.held_fault_out;
         SEL_FAULT: v = f.fault_out;
         default: hit = 1'b0;
      endcase
      return hit & (v ^ neg);
   endfunction : route

   function automatic freq_t clamp_f(logic [15:0] w);
      return (w > FREQ_MAX) ? FREQ_MAX : w;
   endfunction : clamp_f

   // ***************************************
   // Next state
   // ***************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.rdata = '0;
      sel_idx = addr - A_SEL0;

      // Register writes
      if (wr_stb) begin
         if (addr == A_CTRL) begin
            s_nxt.method = ctrl_method_t'(wdata[3:0]);
         end else if (addr == A_BAND) begin
            s_nxt.band = (wdata > 16'(BAND_MAX)) ? BAND_MAX : wdata[6:0];
         end else if (addr == A_TH1) begin
            s_nxt.th1 = clamp_f(wdata);
         end else if (addr == A_THREV) begin
            s_nxt.threv = clamp_f(wdata);
         end else if (addr == A_TH2) begin
            s_nxt.th2 = clamp_f(wdata);
         end else if (addr == A_TH3) begin
            s_nxt.th3 = clamp_f(wdata);
         end else if (addr == A_LOW) begin
            s_nxt.low = clamp_f(wdata);
         end else if (addr == A_STALL) begin
            s_nxt.stall_lvl = wdata;
         end else if (addr >= A_SEL0 && sel_idx < 8'(TERMS)) begin
            s_nxt.sel[sel_idx] = wdata[7:0];
         end
      end

      // Register reads, answered next cycle
      if (rd_stb) begin
         if (addr == A_CTRL) begin
            s_nxt.rdata = {12'h000, s_r.method};
         end else if (addr == A_BAND) begin
            s_nxt.rdata = {9'h000, s_r.band};
         end else if (addr == A_TH1) begin
            s_nxt.rdata = s_r.th1;
         end else if (addr == A_THREV) begin
            s_nxt.rdata = s_r.threv;
         end else if (addr == A_TH2) begin
            s_nxt.rdata = s_r.th2;
         end else if (addr == A_TH3) begin
            s_nxt.rdata = s_r.th3;
         end else if (addr == A_LOW) begin
            s_nxt.rdata = s_r.low;
         end else if (addr == A_STALL) begin
            s_nxt.rdata = s_r.stall_lvl;
         end else if (addr == A_STAT) begin
            s_nxt.rdata = {3'h0, s_r.flg};
         end else if (addr >= A_SEL0 && sel_idx < 8'(TERMS)) begin
            s_nxt.rdata = {8'h00, s_r.sel[sel_idx]};
         end
      end

      // Compared and speed frequencies by method
      case (s_r.method)
         CM_FLUX: begin
            cmp = frq.slip_pre_freq;
            spd = frq.out_freq;
         end
         CM_SLV: begin
            cmp = frq.est_speed;
            spd = frq.est_speed;
         end
         CM_VEC: begin
            cmp = frq.fb_speed;
            spd = frq.fb_speed;
         end
         default: begin
            cmp = frq.out_freq;
            spd = frq.out_freq;
         end
      endcase

      // Direction-dependent first threshold
      if (drv.reverse && s_r.threv != REV_SAME) begin
         th_dir = s_r.threv;
      end else begin
         th_dir = s_r.th1;
      end

      // Frequency flags, all dropped when blanked
      blank = drv.dc_brake | drv.pre_excite | drv.start_tuning;
      s_nxt.flg.freq_reached = !blank && in_band(cmp, frq.set_freq, s_r.band);
      s_nxt.flg.out_freq_detect_1 = !blank && frq.out_freq >= th_dir;
      s_nxt.flg.speed_detect_1 = !blank && spd >= th_dir;
      s_nxt.flg.out_freq_detect_2 = !blank && frq.out_freq >= s_r.th2;
      s_nxt.flg.speed_detect_2 = !blank && spd >= s_r.th2;
      s_nxt.flg.out_freq_detect_3 = !blank && frq.out_freq >= s_r.th3;
      s_nxt.flg.speed_detect_3 = !blank && spd >= s_r.th3;
      s_nxt.flg.low_speed_flag = !blank && cmp < s_r.low;

      // Regen flag with minimum on-time
      if (s_r.method != CM_VEC) begin
         s_nxt.flg.regen_flag = 1'b0;
         s_nxt.hold_cnt = '0;
      end else if (drv.stopped || drv.pre_excite) begin
         s_nxt.flg.regen_flag = 1'b0;
         s_nxt.hold_cnt = '0;
      end else if (drv.regen_status) begin
         s_nxt.flg.regen_flag = 1'b1;
         s_nxt.hold_cnt = HOLD_LOAD;
      end else if (s_r.hold_cnt != '0) begin
         s_nxt.hold_cnt = s_r.hold_cnt - HW'(1);
      end else begin
         s_nxt.flg.regen_flag = 1'b0;
      end

      // Stall watch; alarm holds until the drive resets
      stall_cond = drv.speed_ctrl && (s_r.method == CM_SLV || s_r.method == CM_VEC)
         && drv.torque_limiting && cmp <= s_r.low && frq.torque > s_r.stall_lvl;
      if (drv.alarm_reset) begin
         s_nxt.stall_cnt = '0;
         s_nxt.flg.stall_alarm = 1'b0;
      end else if (stall_cond) begin
         if (s_r.stall_cnt == STALL_END) begin
            s_nxt.flg.stall_alarm = 1'b1;
         end else begin
            s_nxt.stall_cnt = s_r.stall_cnt + SW'(1);
         end
      end else begin
         s_nxt.stall_cnt = '0;
      end

      // Alarm outputs
      s_nxt.flg.fault_out = drv.alarm_stop;
      s_nxt.flg.held_fault_out = drv.alarm_stop | drv.alarm_reset;
      s_nxt.flg.input_contactor_trip = drv.alarm_stop
         && drv.alarm_cause >= CAUSE_FIRST && drv.alarm_cause <= CAUSE_LAST;

      // Terminals follow the flags of the same edge
      for (int i = 0; i < TERMS; i++) begin
         s_nxt.term[i] = route(s_r.sel[i], s_nxt.flg);
      end
   end

   // ***************************************
   // State register
   // ***************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.method <= CM_VF;
         s_r.band <= BAND_RST;
         s_r.th1 <= TH1_RST;
         s_r.threv <= REV_SAME;
         s_r.th2 <= TH2_RST;
         s_r.th3 <= TH3_RST;
         s_r.low <= LOW_RST;
         s_r.stall_lvl <= STALL_RST;
         for (int i = 0; i < TERMS; i++) begin
            s_r.sel[i] <= SEL_NONE;
         end
         s_r.sel[T_SU] <= SEL_SU;
         s_r.sel[T_FU] <= SEL_FU;
         s_r.sel[T_RELAY] <= SEL_FAULT;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign rdata = s_r.rdata;
   assign flags = s_r.flg;
   assign term_out = s_r.term;

endmodule : drive_status_signal_generator

// ===== testbench/status_reader.sv
`timescale 1ns/1ps
// ****
// Controller side: reads the status terminals
// ****
module status_reader (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [6:0] term_out,
   output logic [6:0] seen
);
   // One register stage, like a remote input card; adds a cycle of lag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seen <= 7'h00;
      end else begin
         seen <= term_out;
      end
   end
endmodule : status_reader

// ===== testbench/drive_status_chk.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module drive_status_chk
   import drive_status_pkg::*;
#(
   parameter int REGEN_HOLD_CYCLES = 20,
   parameter int STALL_CYCLES = 30,
   parameter int TERMS = 7
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [15:0] rdata,
   input drive_status_pkg::drive_in_t drv,
   input drive_status_pkg::freq_in_t frq,
   input drive_status_pkg::flags_t flags,
   input wire logic [TERMS-1:0] term_out
);
   import drive_status_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   int quiet_r;
   logic trip_want;
   // Cycles since regen last seen, saturating so it cannot wrap
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         quiet_r <= 0;
      end else if (drv.regen_status) begin
         quiet_r <= 0;
      end else if (quiet_r < REGEN_HOLD_CYCLES) begin
         quiet_r <= quiet_r + 1;
      end
   end
   // Alarm causes that should open the input contactor
   assign trip_want = drv.alarm_stop && drv.alarm_cause >= CAUSE_FIRST
      && drv.alarm_cause <= CAUSE_LAST;
   sequence alarm_then_reset;
      drv.alarm_stop ##1 drv.alarm_reset;
   endsequence
   a_fault_on: assert property (
      drv.alarm_stop |=> flags.fault_out && flags.held_fault_out)
      else $error("fault outputs missing after alarm stop");
   a_held_reset: assert property (
      alarm_then_reset |=> flags.held_fault_out)
      else $error("held fault dropped in reset period");
   a_trip_cause: assert property (
      1'b1 |=> flags.input_contactor_trip == $past(trip_want))
      else $error("contactor trip wrong for alarm cause");
   a_freq_blank: assert property (
      (drv.dc_brake || drv.pre_excite || drv.start_tuning) |=> flags[7:0] == 8'h00)
      else $error("frequency flags not blanked");
   a_regen_hold: assert property (
      $fell(flags.regen_flag) && !$past(drv.stopped) && !$past(drv.pre_excite)
      && !$past(drv.regen_status) |-> quiet_r >= REGEN_HOLD_CYCLES - 1)
      else $error("regen flag released too early");
   a_regen_stop: assert property (
      (drv.stopped || drv.pre_excite) |=> !flags.regen_flag)
      else $error("regen flag high while stopped");
   a_stall_keep: assert property (
      flags.stall_alarm && !drv.alarm_reset |=> flags.stall_alarm)
      else $error("stall alarm cleared without reset");
   a_read_idle: assert property (
      !rd_stb |=> rdata == 16'h0000)
      else $error("read data not idle");
endmodule : drive_status_chk

bind drive_status_signal_generator drive_status_chk #(
   .REGEN_HOLD_CYCLES(REGEN_HOLD_CYCLES),
   .STALL_CYCLES(STALL_CYCLES),
   .TERMS(TERMS)
) u_drive_status_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
   .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .drv(drv), .frq(frq),
   .flags(flags), .term_out(term_out));

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import drive_status_pkg::*;
   typedef struct {freq_t f; logic [7:0] e;} row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [15:0] rdata;
   drive_in_t drv = '0;
   freq_in_t frq = '0;
   flags_t flags;
   logic [6:0] term_out;
   logic [6:0] seen;
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   // Set 50 Hz, band 10 %: reached from 45 Hz to 55 Hz
   row_t rows[8] = '{'{16'h0064, 8'h80}, '{16'h0096, 8'h00}, '{16'h0257, 8'h00},
      '{16'h0258, 8'h06}, '{16'h0bb8, 8'h1e}, '{16'h1194, 8'h1f},
      '{16'h1388, 8'h1f}, '{16'h1770, 8'h7e}};
   logic [7:0] codes[9] = '{SEL_FU, SEL_FB, SEL_FU2, SEL_FB2, SEL_FU3, SEL_FB3,
      SEL_LS, SEL_HELD, SEL_TRIP};
   logic [8:0] vals = 9'b110001111;

   // ****
   // Clock, design and reader
   // ****
   always #20 clk = ~clk;
   drive_status_signal_generator #(.REGEN_HOLD_CYCLES(20), .STALL_CYCLES(30))
      u_drive_status_signal_generator (.clk(clk), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .drv(drv),
      .frq(frq), .flags(flags), .term_out(term_out));
   status_reader u_status_reader (.clk(clk), .rst_n(rst_n), .term_out(term_out),
      .seen(seen));

   // ****
   // Helpers
   // ****
   task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // Sample at the falling edge, clear of the launch edge
   task settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      chk("rdata", rdata, e);
   endtask : rd
   task results;
      $display("TB: checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         results();
      end
   end

   // ****
   // Tests
   // ****
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      frq.set_freq <= 16'h1388;
      rd(A_TH1, 16'h0258);
      rd(A_THREV, 16'h270f);
      rd(A_SEL0 + 8'h05, 16'h0063);
      rd(8'h30, 16'h0000);
      wr(A_BAND, 16'h00c8);
      rd(A_BAND, 16'h0064);
      wr(A_BAND, 16'h000a);
      foreach (rows[i]) begin
         @(posedge clk) frq.out_freq <= rows[i].f;
         settle(2);
         chk("freq flags", flags[7:0], rows[i].e);
         chk("term su", term_out[T_SU], rows[i].e[0]);
         chk("term fu", term_out[T_FU], rows[i].e[1]);
      end
      $display("TB: table done");
      // Reverse threshold, shared then separate
      @(posedge clk);
      drv.reverse <= 1'b1;
      frq.out_freq <= 16'h0258;
      settle(2);
      chk("rev same", flags.out_freq_detect_1, 1'b1);
      wr(A_THREV, 16'h03e8);
      settle(2);
      chk("rev own", flags.out_freq_detect_1, 1'b0);
      @(posedge clk) drv.reverse <= 1'b0;
      settle(2);
      chk("fwd", flags.out_freq_detect_1, 1'b1);
      // Output 7 Hz, every other source 1 Hz
      @(posedge clk);
      frq.out_freq <= 16'h02bc;
      frq.slip_pre_freq <= 16'h0064;
      frq.est_speed <= 16'h0064;
      frq.fb_speed <= 16'h0064;
      for (int m = 0; m < 4; m++) begin
         wr(A_CTRL, 16'h0001 << m);
         settle(2);
         chk("low by method", flags.low_speed_flag, m != 0);
         chk("speed flag", flags.speed_detect_1, m < 2);
      end
      $display("TB: sources done");
      @(posedge clk) drv.regen_status <= 1'b1;
      @(posedge clk) drv.regen_status <= 1'b0;
      @(negedge clk);
      chk("regen on", flags.regen_flag, 1'b1);
      settle(15);
      chk("regen held", flags.regen_flag, 1'b1);
      settle(10);
      chk("regen off", flags.regen_flag, 1'b0);
      @(posedge clk);
      drv.stopped <= 1'b1;
      drv.regen_status <= 1'b1;
      settle(2);
      chk("regen stop", flags.regen_flag, 1'b0);
      @(posedge clk);
      drv.stopped <= 1'b0;
      drv.pre_excite <= 1'b1;
      settle(2);
      chk("regen pre", flags.regen_flag, 1'b0);
      @(posedge clk) drv.pre_excite <= 1'b0;
      wr(A_CTRL, 16'h0001);
      settle(2);
      chk("regen vf", flags.regen_flag, 1'b0);
      wr(A_CTRL, 16'h0008);
      settle(2);
      chk("regen vec", flags.regen_flag, 1'b1);
      @(posedge clk) drv.regen_status <= 1'b0;
      $display("TB: regen done");
      @(posedge clk) frq.out_freq <= 16'h1770;
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         drv.dc_brake <= k == 0;
         drv.pre_excite <= k == 1;
         drv.start_tuning <= k == 2;
         settle(2);
         chk("blanked", flags[7:0], 8'h00);
      end
      // Stall: 1 Hz under torque limit, torque 200 % over 150 %
      @(posedge clk);
      drv.start_tuning <= 1'b0;
      drv.speed_ctrl <= 1'b1;
      drv.torque_limiting <= 1'b1;
      frq.torque <= 16'h07d0;
      settle(20);
      chk("stall early", flags.stall_alarm, 1'b0);
      settle(20);
      chk("stall", flags.stall_alarm, 1'b1);
      @(posedge clk);
      drv.torque_limiting <= 1'b0;
      drv.alarm_reset <= 1'b1;
      settle(2);
      chk("stall clear", flags.stall_alarm, 1'b0);
      chk("held in reset", flags.held_fault_out, 1'b1);
      @(posedge clk) drv.alarm_reset <= 1'b0;
      for (int c = 0; c < 13; c++) begin
         @(posedge clk);
         drv.alarm_stop <= 1'b1;
         drv.alarm_cause <= 5'(c);
         settle(2);
         chk("trip", flags.input_contactor_trip, c > 0 && c < 12);
         chk("fault", {flags.fault_out, flags.held_fault_out}, 2'b11);
         chk("relay", term_out[T_RELAY], 1'b1);
      end
      $display("TB: alarms done");
      // Output 30 Hz under V/F with an alarm from cause 3
      @(posedge clk);
      drv.alarm_cause <= 5'h03;
      frq.out_freq <= 16'h0bb8;
      wr(A_CTRL, 16'h0001);
      for (int i = 0; i < 18; i++) begin
         wr(A_SEL0 + 8'h02, {8'h00, codes[i % 9] + (i > 8 ? NEG_OFS : 8'h00)});
         settle(3);
         chk("routed", seen[2], vals[i % 9] ^ (i > 8));
      end
      @(posedge clk) rst_n <= 1'b0;
      @(negedge clk);
      chk("reset term", term_out, 7'h00);
      @(posedge clk) rst_n <= 1'b1;
      rd(A_SEL0 + 8'h02, 16'h00ff);
      $display("TB: routing done");
      results();
   end
endmodule : tb_top
